// ### logic/swp_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Hold chip reset until all supplies good.
// - Supply drop forces reset, then cold restart.
// - External reset pin optional, idles high.
// - Sixteen-bit watchdog counting in milliseconds.
// - Watchdog timeout programmable 1 ms to 65 s.
// - Missed watchdog reload resets the chip.
// - Readable flag: last reset was watchdog.
// - Watchdog runs only in running state.
// - Sleep request starts run-to-quiescent transition.
// - Transitions step through intermediate states.
// - Pin or timer wake starts wake transition.
// - Wake stimuli ignored while running.
// - Wake during sleep entry held until asleep.
// - Wake pin polarity chosen by software.
// - Wake when 64-bit counter reaches target.
// - Counter ticks on main oscillator while running.
// - Counter may switch to slow oscillator asleep.
// - Slow ticks add programmed increment.
// - Asleep: node powered down, sleep logic alive.
// - 128-byte memory retained through sleep.
// - Supply loss during transition forces reset.
module swp_supervisor
  import swp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Supplies and external reset
  input wire logic [3:0] supply_good,
  input wire logic ext_rst_b,
  // Watchdog control
  input wire logic wdog_enable,
  input wire logic wdog_reload,
  input wire logic [WDOG_W-1:0] wdog_timeout,
  // Power mode control
  input wire logic sleep_req,
  input wire swp_sleep_cfg_t sleep_cfg,
  input wire swp_wake_cfg_t wake_cfg,
  input wire logic wake_pin,
  // Counter programming
  input wire logic osc_tick,
  input wire logic [RTC_W-1:0] rtc_wake_value,
  input wire logic [RTC_W-1:0] rtc_slow_inc,
  // Retained memory
  input wire logic mem_we,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  // Status and power outputs
  output logic chip_rst_b,
  output logic wdog_reset_cause,
  output swp_pwr_t pwr_state,
  output logic node_power_en,
  output swp_sleep_cfg_t sleep_out,
  output logic [RTC_W-1:0] rtc_value
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    swp_pwr_t pwr;
    logic [2:0] step;
    logic chip_rst_b;
    logic wdog_cause;
    logic wake_pend;
    logic slow_mode;
    logic [11:0] slow_cnt;
    logic [RTC_W-1:0] rtc;
    logic node_on;
    swp_sleep_cfg_t sleep_out;
    logic [31:0] rdata;
  } swp_st_t;

  swp_st_t st_q;
  swp_st_t st_d;
  logic [31:0] mem_q [MEM_WORDS];
  logic wdog_expire;
  logic supplies_ok;
  logic pin_wake;
  logic rtc_wake;
  logic wake_now;
  logic in_transit;

  function automatic logic is_transit(input swp_pwr_t s);
    return s != SWP_PWR_AWAKE && s != SWP_PWR_ASLEEP;
  endfunction

  assign supplies_ok = &supply_good;
  assign pin_wake = wake_cfg.wake_pin_en &&
                    (wake_pin == wake_cfg.wake_pin_pol);
  assign rtc_wake = wake_cfg.wake_rtc_en &&
                    (st_q.rtc >= rtc_wake_value);
  assign wake_now = pin_wake || rtc_wake;
  assign in_transit = is_transit(st_q.pwr);

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  swp_wdog u_wdog (
    .clk(clk),
    .rst_b(rst_b),
    .run(st_q.pwr == SWP_PWR_AWAKE && st_q.chip_rst_b),
    .enable(wdog_enable && st_q.chip_rst_b),
    .reload(wdog_reload),
    .timeout(wdog_timeout),
    .expire(wdog_expire)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rdata = mem_q[mem_addr];
    // Counter advances on main ticks, or slow ticks when switched.
    if (st_q.slow_mode) begin
      if (st_q.slow_cnt == 12'(SLOW_TICK_CYC - 1)) begin
        st_d.slow_cnt = '0;
        st_d.rtc = st_q.rtc + rtc_slow_inc;
      end else begin
        st_d.slow_cnt = st_q.slow_cnt + 12'h001;
      end
    end else if (osc_tick) begin
      st_d.rtc = st_q.rtc + 64'h0000_0000_0000_0001;
    end
    if (in_transit && wake_now) begin
      st_d.wake_pend = 1'b1;
    end
    if (in_transit && st_q.step != 3'(STEP_CYC - 1)) begin
      st_d.step = st_q.step + 3'h1;
    end
    case (st_q.pwr)
      SWP_PWR_AWAKE: begin
        st_d.wake_pend = 1'b0;
        if (sleep_req) begin
          st_d.pwr = SWP_PWR_SLEEP_STEP1;
          st_d.step = '0;
        end
      end
      SWP_PWR_SLEEP_STEP1: begin
        if (st_q.step == 3'(STEP_CYC - 1)) begin
          st_d.pwr = SWP_PWR_SLEEP_STEP2;
          st_d.step = '0;
          st_d.sleep_out = sleep_cfg;
        end
      end
      SWP_PWR_SLEEP_STEP2: begin
        if (st_q.step == 3'(STEP_CYC - 1)) begin
          st_d.pwr = SWP_PWR_ASLEEP;
          st_d.node_on = 1'b0;
          st_d.slow_mode = wake_cfg.rtc_slow_en;
          st_d.slow_cnt = '0;
        end
      end
      SWP_PWR_ASLEEP: begin
        if (wake_now || st_q.wake_pend) begin
          st_d.pwr = SWP_PWR_WAKE_STEP1;
          st_d.step = '0;
          st_d.wake_pend = 1'b0;
          st_d.slow_mode = 1'b0;
          st_d.sleep_out = '0;
        end
      end
      SWP_PWR_WAKE_STEP1: begin
        if (st_q.step == 3'(STEP_CYC - 1)) begin
          st_d.pwr = SWP_PWR_WAKE_STEP2;
          st_d.step = '0;
          st_d.node_on = 1'b1;
        end
      end
      SWP_PWR_WAKE_STEP2: begin
        if (st_q.step == 3'(STEP_CYC - 1)) begin
          st_d.pwr = SWP_PWR_AWAKE;
        end
      end
      default: begin
        st_d.pwr = SWP_PWR_AWAKE;
      end
    endcase
    st_d.chip_rst_b = 1'b1;
    if (wdog_expire) begin
      st_d.chip_rst_b = 1'b0;
      st_d.wdog_cause = 1'b1;
    end
    if (!supplies_ok || !ext_rst_b) begin
      st_d.chip_rst_b = 1'b0;
      st_d.wdog_cause = 1'b0;
    end
    if (!st_d.chip_rst_b) begin
      // Cold-start everything except the retained memory, cause and counter.
      st_d.pwr = SWP_PWR_AWAKE;
      st_d.step = '0;
      st_d.wake_pend = 1'b0;
      st_d.slow_mode = 1'b0;
      st_d.node_on = 1'b1;
      st_d.sleep_out = '0;
    end
    if (!supplies_ok) begin
      st_d.rtc = '0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{pwr: SWP_PWR_AWAKE, node_on: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Retained memory: kept while asleep, no reset clears it.
  always_ff @(posedge clk) begin
    if (mem_we && st_q.pwr == SWP_PWR_AWAKE) begin
      mem_q[mem_addr] <= mem_wdata;
    end
  end

  assign chip_rst_b = st_q.chip_rst_b;
  assign wdog_reset_cause = st_q.wdog_cause;
  assign pwr_state = st_q.pwr;
  assign node_power_en = st_q.node_on;
  assign sleep_out = st_q.sleep_out;
  assign rtc_value = st_q.rtc;
  assign mem_rdata = st_q.rdata;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  supply_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
    !supplies_ok |=> !chip_rst_b)
    else $error("Supply loss did not reset the chip.");

  transit_loss_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_transit && !supplies_ok |=> pwr_state == SWP_PWR_AWAKE
      && !chip_rst_b)
    else $error("Supply loss in transition not handled.");

  wdog_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
    wdog_expire && supplies_ok && ext_rst_b |=> !chip_rst_b
      && wdog_reset_cause)
    else $error("Watchdog expiry did not reset with cause.");

  sleep_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    pwr_state == SWP_PWR_AWAKE && sleep_req && st_d.chip_rst_b
      |=> pwr_state == SWP_PWR_SLEEP_STEP1)
    else $error("Sleep request not taken.");

  sleep_steps_a: assert property (@(posedge clk)
    disable iff (!rst_b || !supplies_ok || !ext_rst_b)
    $rose(pwr_state == SWP_PWR_SLEEP_STEP1) && supplies_ok
      && ext_rst_b && !wdog_expire
      |-> (pwr_state == SWP_PWR_SLEEP_STEP1)[*4])
    else $error("Sleep entry skipped a step.");

  awake_ignore_a: assert property (@(posedge clk) disable iff (!rst_b)
    pwr_state == SWP_PWR_AWAKE && !sleep_req |=> pwr_state
      == SWP_PWR_AWAKE)
    else $error("Wake stimulus acted on while running.");

  held_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
    pwr_state == SWP_PWR_ASLEEP && st_q.wake_pend && chip_rst_b
      && st_d.chip_rst_b |=> pwr_state == SWP_PWR_WAKE_STEP1)
    else $error("Held wake was lost.");

  rtc_main_a: assert property (@(posedge clk) disable iff (!rst_b)
    !st_q.slow_mode && osc_tick && supplies_ok |=> rtc_value
      == $past(rtc_value) + 64'h0000_0000_0000_0001)
    else $error("Counter missed a main tick.");

  asleep_node_a: assert property (@(posedge clk) disable iff (!rst_b)
    pwr_state == SWP_PWR_ASLEEP |-> !node_power_en)
    else $error("Node powered while asleep.");

  sleep_cycle_c: cover property (@(posedge clk) disable iff (!rst_b)
    pwr_state == SWP_PWR_ASLEEP ##[1:300] pwr_state == SWP_PWR_AWAKE);
  pend_wake_c: cover property (@(posedge clk) disable iff (!rst_b)
    in_transit && wake_now && pwr_state == SWP_PWR_SLEEP_STEP2);
  wdog_hit_c: cover property (@(posedge clk) disable iff (!rst_b)
    wdog_expire);

endmodule
`default_nettype wire

// ### logic/swp_pkg.sv
package swp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WDOG_TICK_US = 1000;
  localparam int unsigned WDOG_TICK_CYC = (WDOG_TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SLOW_OSC_HZ = 31250;
  localparam int unsigned SLOW_TICK_CYC = 125000000 / SLOW_OSC_HZ;
  localparam int unsigned STEP_CYC = 4;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned WDOG_W = 16;
  localparam int unsigned RTC_W = 64;
  localparam int unsigned MEM_WORDS = 32;
  localparam int unsigned MEM_AW = 5;
  localparam logic [WDOG_W-1:0] WDOG_TIMEOUT_RST = 16'hFFFF;
  localparam logic [RTC_W-1:0] RTC_INC_RST = 64'h0000_0000_0000_0001;
  localparam logic [3:0] SLEEP_CFG_RST = 4'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SWP_PWR_AWAKE,
    SWP_PWR_SLEEP_STEP1,
    SWP_PWR_SLEEP_STEP2,
    SWP_PWR_ASLEEP,
    SWP_PWR_WAKE_STEP1,
    SWP_PWR_WAKE_STEP2
  } swp_pwr_t;

  typedef struct packed {
    logic second_buck_supply_only;
    logic pulse_frequency_supply_mode;
    logic clock_mask;
    logic assert_reset;
  } swp_sleep_cfg_t;

  typedef struct packed {
    logic wake_pin_en;
    logic wake_pin_pol;
    logic wake_rtc_en;
    logic rtc_slow_en;
  } swp_wake_cfg_t;

endpackage

// ### logic/swp_wdog.sv
`timescale 1ns/10ps
`default_nettype none
module swp_wdog
  import swp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic enable,
  input wire logic reload,
  input wire logic [WDOG_W-1:0] timeout,
  // Status
  output logic expire
);

  typedef struct packed {
    logic [19:0] pre;
    logic [WDOG_W-1:0] ms;
    logic expire;
  } swp_wdog_st_t;

  swp_wdog_st_t st_q;
  swp_wdog_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.expire = 1'b0;
    if (!enable || reload) begin
      st_d.pre = '0;
      st_d.ms = '0;
    end else if (run) begin
      if (st_q.pre == 20'(WDOG_TICK_CYC - 1)) begin
        st_d.pre = '0;
        st_d.ms = st_q.ms + 16'h0001;
        if (st_q.ms + 16'h0001 >= timeout) begin
          st_d.expire = 1'b1;
          st_d.ms = '0;
        end
      end else begin
        st_d.pre = st_q.pre + 20'h0_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expire = st_q.expire;

  hold_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
    !run && enable && !reload |=> $stable(st_q.ms))
    else $error("Watchdog count moved outside running state.");

endmodule
`default_nettype wire

// ### sim/swp_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module swp_far_side
  import swp_pkg::*;
#(
  parameter int TICK_DIV = 5,
  parameter int RAMP_CYC = 6
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Supply faults asked for by the bench
  input wire logic [3:0] drop,
  // Oscillator and supplies
  output logic osc_tick,
  output logic [3:0] supply_good
);
  logic [7:0] div_q;
  logic [7:0] ramp_q;

  // ---------------------------------------------------------------
  // Supplies ramp up after power-up, then follow the fault request
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 8'h00;
      ramp_q <= 8'h00;
    end else begin
      if (ramp_q != 8'(RAMP_CYC)) begin
        ramp_q <= ramp_q + 8'h01;
      end
      if (div_q == 8'(TICK_DIV - 1)) begin
        div_q <= 8'h00;
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  assign osc_tick = (div_q == 8'h00);
  assign supply_good = (ramp_q == 8'(RAMP_CYC)) ? ~drop : 4'h0;
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
  import swp_pkg::*;
;
  logic clk, rst_b, ext_rst_b, wdog_enable, wdog_reload, sleep_req, ok;
  logic wake_pin, osc_tick, mem_we, chip_rst_b, cause, node_power_en;
  logic [3:0] supply_good, drop;
  logic [WDOG_W-1:0] wdog_timeout;
  logic [RTC_W-1:0] rtc_wake_value, rtc_slow_inc, rtc_value, base;
  logic [MEM_AW-1:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata;
  logic [2:0] pin_rows [4];
  swp_sleep_cfg_t sleep_cfg, sleep_out;
  swp_wake_cfg_t wake_cfg;
  swp_pwr_t pwr_state;
  int n_mismatch, n_compared, cyc, t0;

  swp_far_side far (.clk(clk), .rst_b(rst_b), .drop(drop),
    .osc_tick(osc_tick), .supply_good(supply_good));

  swp_supervisor DUT (.clk(clk), .rst_b(rst_b), .supply_good(supply_good),
    .ext_rst_b(ext_rst_b), .wdog_enable(wdog_enable),
    .wdog_reload(wdog_reload), .wdog_timeout(wdog_timeout),
    .sleep_req(sleep_req), .sleep_cfg(sleep_cfg), .wake_cfg(wake_cfg),
    .wake_pin(wake_pin), .osc_tick(osc_tick),
    .rtc_wake_value(rtc_wake_value), .rtc_slow_inc(rtc_slow_inc),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .chip_rst_b(chip_rst_b),
    .wdog_reset_cause(cause), .pwr_state(pwr_state),
    .node_power_en(node_power_en), .sleep_out(sleep_out),
    .rtc_value(rtc_value));

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_st(input swp_pwr_t got, input swp_pwr_t exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_state(input swp_pwr_t s, input int max);
    for (int i = 0; i < max && pwr_state !== s; i++) begin
      @(posedge clk);
      #1;
    end
    cmp_st(pwr_state, s);
  endtask

  task automatic wait_chip(input int max);
    for (int i = 0; i < max && chip_rst_b !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    cmp(chip_rst_b, 1'b1);
  endtask

  // Walks the sleep entry and checks every step on its exact cycle.
  task automatic go_sleep();
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    #1;
    cmp_st(pwr_state, SWP_PWR_SLEEP_STEP1);
    repeat (4) @(posedge clk);
    #1;
    cmp_st(pwr_state, SWP_PWR_SLEEP_STEP2);
    repeat (4) @(posedge clk);
    #1;
    cmp_st(pwr_state, SWP_PWR_ASLEEP);
    cmp(node_power_en, 1'b0);
    cmp(sleep_out, sleep_cfg);
  endtask

  task automatic wake_walk();
    repeat (4) @(posedge clk);
    #1;
    cmp_st(pwr_state, SWP_PWR_WAKE_STEP2);
    cmp(node_power_en, 1'b1);
    repeat (4) @(posedge clk);
    #1;
    cmp_st(pwr_state, SWP_PWR_AWAKE);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 200000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    ext_rst_b = 1'b1;
    wdog_enable = 1'b0;
    wdog_reload = 1'b0;
    wdog_timeout = 16'hFFFF;
    sleep_req = 1'b0;
    sleep_cfg = '{1'b1, 1'b1, 1'b1, 1'b1};
    wake_cfg = '{1'b1, 1'b1, 1'b0, 1'b0};
    wake_pin = 1'b0;
    rtc_wake_value = 64'hFFFF_FFFF_FFFF_FFFF;
    rtc_slow_inc = 64'h0000_0000_0001_0000;
    mem_we = 1'b0;
    mem_addr = 5'h1F;
    mem_wdata = 32'hA5C3_0F96;
    drop = 4'h0;
    // Each row is polarity, pin level, and whether the device wakes.
    pin_rows = '{3'b111, 3'b100, 3'b001, 3'b010};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    cmp(chip_rst_b, 1'b0);
    wait_chip(12);
    cmp(cause, 1'b0);
    end_test("power_on");
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      wake_cfg <= '{1'b1, pin_rows[r][2], 1'b0, 1'b0};
      wake_pin <= ~pin_rows[r][2];
      go_sleep();
      @(posedge clk);
      wake_pin <= pin_rows[r][1];
      repeat (6) @(posedge clk);
      #1;
      cmp(pwr_state != SWP_PWR_ASLEEP, pin_rows[r][0]);
      if (!pin_rows[r][0]) begin
        @(posedge clk);
        wake_pin <= pin_rows[r][2];
        wait_state(SWP_PWR_WAKE_STEP1, 6);
      end
      wait_state(SWP_PWR_AWAKE, 12);
      end_test("pin_row");
    end
    @(posedge clk);
    mem_we <= 1'b1;
    @(posedge clk);
    mem_we <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    cmp_st(pwr_state, SWP_PWR_AWAKE);
    go_sleep();
    wait_state(SWP_PWR_WAKE_STEP1, 2);
    wake_walk();
    @(posedge clk);
    #1;
    cmp(mem_rdata, 32'hA5C3_0F96);
    end_test("held_wake_and_memory");
    @(posedge clk);
    wake_pin <= 1'b0;
    #1;
    base = rtc_value;
    for (int i = 0; i < 10 && rtc_value === base; i++) begin
      @(posedge clk);
      #1;
    end
    base = rtc_value;
    repeat (50) @(posedge clk);
    #1;
    cmp(rtc_value - base, 64'h0000_0000_0000_000A);
    @(posedge clk);
    wake_cfg <= '{1'b0, 1'b1, 1'b1, 1'b1};
    go_sleep();
    repeat (2) @(posedge clk);
    #1;
    base = rtc_value;
    for (int i = 0; i < 4100 && rtc_value === base; i++) begin
      @(posedge clk);
      #1;
    end
    cmp(rtc_value - base, rtc_slow_inc);
    @(posedge clk);
    rtc_wake_value <= base + rtc_slow_inc + rtc_slow_inc - 64'h1;
    repeat (SLOW_TICK_CYC - 50) @(posedge clk);
    #1;
    cmp_st(pwr_state, SWP_PWR_ASLEEP);
    wait_state(SWP_PWR_WAKE_STEP1, 100);
    wait_state(SWP_PWR_AWAKE, 12);
    end_test("counter_wake");
    @(posedge clk);
    wake_cfg <= '{1'b1, 1'b1, 1'b0, 1'b0};
    wdog_timeout <= 16'h0001;
    wdog_enable <= 1'b1;
    t0 = cyc;
    for (int i = 0; i < 126000 && chip_rst_b !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    ok = (cyc - t0 > 124990) && (cyc - t0 < 125010);
    cmp(ok, 1'b1);
    @(posedge clk);
    wdog_enable <= 1'b0;
    wait_chip(10);
    cmp(cause, 1'b1);
    end_test("watchdog");
    @(posedge clk);
    ext_rst_b <= 1'b0;
    @(posedge clk);
    ext_rst_b <= 1'b1;
    #1;
    cmp(chip_rst_b, 1'b0);
    wait_chip(10);
    cmp(cause, 1'b0);
    end_test("external_reset");
    @(posedge clk);
    drop <= 4'h4;
    repeat (3) @(posedge clk);
    #1;
    cmp(chip_rst_b, 1'b0);
    cmp(rtc_value, 64'h0000_0000_0000_0000);
    @(posedge clk);
    drop <= 4'h0;
    wait_chip(10);
    end_test("brown_out");
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge clk);
    drop <= 4'h8;
    repeat (3) @(posedge clk);
    #1;
    cmp(chip_rst_b, 1'b0);
    @(posedge clk);
    drop <= 4'h0;
    wait_chip(10);
    cmp_st(pwr_state, SWP_PWR_AWAKE);
    end_test("transition_supply_loss");
    print_verdict();
  end
endmodule
`default_nettype wire
